// File: hdl/capture_compare_regs.vh
// register offsets, field positions, reset values for the capture/compare channel control
//----------------------------------------
// Summary of operation
//----------------------------------------
`ifndef CAPTURE_COMPARE_REGS_VH
`define CAPTURE_COMPARE_REGS_VH

`define ADDR_W 10
`define OFF_STATUS 10'h123
`define OFF_IO_AB 10'h124
`define OFF_IO_CD 10'h125
`define OFF_CTRL 10'h126

`define RST_IO 8'h88
`define RD_ONES_AB 8'h80
`define RD_ONES_CD 8'h88
`define STATUS_ONES 8'h70

`define BIT_A_MODE 2
`define BIT_A_SRC 3
`define BIT_B_MODE 6
`define BIT_C_MODE 2
`define BIT_D_MODE 6
`define BIT_OVF 7

`define MODE_TIMER 2'h0
`define MODE_PWM 2'h1
`define MODE_PWM2 2'h2

`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2

`endif

// File: hdl/capture_compare_channel_ctrl.v
// capture/compare channel flag and I/O control logic
`timescale 1ns/1ps
`include "capture_compare_regs.vh"

module capture_compare_channel_ctrl #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst,
  // register port
  input wire [`ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // counter and general registers
  input wire [CNT_W-1:0] i_timer_counter,
  input wire i_counter_wrap,
  input wire [CNT_W-1:0] i_general_reg_a,
  input wire [CNT_W-1:0] i_general_reg_b,
  input wire [CNT_W-1:0] i_general_reg_c,
  input wire [CNT_W-1:0] i_general_reg_d,
  // capture inputs
  input wire i_chan_a_pin,
  input wire i_chan_b_pin,
  input wire i_chan_c_pin,
  input wire i_chan_d_pin,
  input wire i_osc_div_128_signal,
  // status outputs
  output reg [3:0] o_chan_event_flag,
  output reg o_counter_wrap_flag,
  output reg [3:0] o_capture_strobe,
  output reg [3:0] o_chan_capture_mode,
  output reg o_buffer_a_active,
  output reg o_buffer_b_active
);

  //----------------------------------------
  // registers
  //----------------------------------------
  reg [7:0] io_control_ab_q;
  reg [7:0] io_control_cd_q;
  reg [1:0] timer_mode_q;
  reg buffer_a_enable_q;
  reg buffer_b_enable_q;
  reg [3:0] flag_q;
  reg wrap_q;
  reg [4:0] seen_one_q;
  reg [3:0] s1_q;
  reg [3:0] s2_q;
  reg [3:0] s3_q;
  reg [3:0] lvl_q;
  reg [3:0] prev_q;
  reg [3:0] cnt_eq_q;

  //----------------------------------------
  // field decode
  //----------------------------------------
  // pwm modes force every channel to compare, whatever the I/O control holds
  wire timer_mode = (timer_mode_q == `MODE_TIMER);
  wire [3:0] pin_raw = {i_chan_d_pin, i_chan_c_pin, i_chan_b_pin, i_chan_a_pin};
  wire chan_a_func_sel = io_control_ab_q[`BIT_A_MODE];
  wire chan_b_func_sel = io_control_ab_q[`BIT_B_MODE];
  wire chan_c_func_sel = io_control_cd_q[`BIT_C_MODE];
  wire chan_d_func_sel = io_control_cd_q[`BIT_D_MODE];
  wire chan_a_trigger_src = io_control_ab_q[`BIT_A_SRC];
  wire a_capture = timer_mode & chan_a_func_sel;
  // oscillator tap used only when channel A captures
  wire a_from_osc = a_capture & ~chan_a_trigger_src;
  wire [3:0] cap_mode;
  assign cap_mode[0] = a_capture;
  assign cap_mode[1] = timer_mode & chan_b_func_sel;
  assign cap_mode[2] = timer_mode & chan_c_func_sel;
  assign cap_mode[3] = timer_mode & chan_d_func_sel;
  wire [1:0] edge_select_field_a = io_control_ab_q[1:0];
  wire [1:0] edge_select_field_b = io_control_ab_q[5:4];
  wire [1:0] edge_select_field_c = io_control_cd_q[1:0];
  wire [1:0] edge_select_field_d = io_control_cd_q[5:4];
  wire [7:0] edge_fields = {edge_select_field_d, edge_select_field_c, edge_select_field_b, edge_select_field_a};
  wire [CNT_W*4-1:0] gr_all = {i_general_reg_d, i_general_reg_c, i_general_reg_b, i_general_reg_a};

  //----------------------------------------
  // per-channel capture edge and match
  //----------------------------------------
  // pins go through three flops; a change is taken once stages two and three agree
  wire [3:0] edge_hit;
  wire [3:0] match_now;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      wire [1:0] sel = edge_fields[2*g+1:2*g];
      wire agreed = (s2_q[g] == s3_q[g]);
      wire nlvl = agreed ? s3_q[g] : lvl_q[g];
      wire rise = nlvl & ~lvl_q[g];
      wire fall = ~nlvl & lvl_q[g];
      reg hit;
      // both codes above falling take either edge
      always @* begin
        case (sel)
          `EDGE_RISE: hit = rise;
          `EDGE_FALL: hit = fall;
          default: hit = rise | fall;
        endcase
      end
      assign edge_hit[g] = hit;
      assign match_now[g] = (i_timer_counter == gr_all[CNT_W*g +: CNT_W]);
    end
  endgenerate

  //----------------------------------------
  // flag set events
  //----------------------------------------
  // oscillator tap is on-chip and synchronous, so it skips the pin synchroniser
  wire osc_edge = i_osc_div_128_signal & ~prev_q[0];
  wire [3:0] trig;
  assign trig[0] = a_from_osc ? osc_edge : edge_hit[0];
  assign trig[1] = edge_hit[1];
  assign trig[2] = edge_hit[2];
  assign trig[3] = edge_hit[3];
  // a match counts once on entry, so a stalled counter does not re-flag every cycle
  wire [3:0] match_rise = match_now & ~cnt_eq_q;
  wire [3:0] cap_ev = cap_mode & trig;
  wire [3:0] cmp_ev = ~cap_mode & match_rise;
  // c/d flag on their own match even when buffering a/b
  wire set_a = cap_ev[0] | cmp_ev[0];
  wire set_b = cap_ev[1] | cmp_ev[1];
  wire set_c = cap_ev[2] | cmp_ev[2];
  wire set_d = cap_ev[3] | cmp_ev[3];
  wire [3:0] set_ev = {set_d, set_c, set_b, set_a};

  //----------------------------------------
  // register access
  //----------------------------------------
  wire wr_status = i_wr & (i_addr == `OFF_STATUS);
  wire wr_ab = i_wr & (i_addr == `OFF_IO_AB);
  wire wr_cd = i_wr & (i_addr == `OFF_IO_CD);
  wire wr_ctrl = i_wr & (i_addr == `OFF_CTRL);
  wire rd_status = i_rd & (i_addr == `OFF_STATUS);
  wire [4:0] cur_flags = {wrap_q, flag_q};
  // write data lined up with the flag bits, overflow on top
  wire [4:0] wr_bits = {i_wdata[`BIT_OVF], i_wdata[3:0]};
  // a bit clears only if written 0 and armed by an earlier read of 1
  wire [4:0] clr = {5{wr_status}} & ~wr_bits & seen_one_q;

  reg [7:0] rdata_d;
  always @* begin
    case (i_addr)
      `OFF_STATUS: rdata_d = {wrap_q, 3'h7, flag_q};
      `OFF_IO_AB: rdata_d = io_control_ab_q | `RD_ONES_AB;
      `OFF_IO_CD: rdata_d = io_control_cd_q | `RD_ONES_CD;
      `OFF_CTRL: rdata_d = {2'h0, buffer_b_enable_q, buffer_a_enable_q, 2'h0, timer_mode_q};
      default: rdata_d = 8'h00;
    endcase
  end

  //----------------------------------------
  // next flag values
  //----------------------------------------
  // set beats a simultaneous clear so no event is lost
  wire [3:0] flag_d = (flag_q & ~clr[3:0]) | set_ev;
  wire wrap_d = (wrap_q & ~clr[4]) | i_counter_wrap;

  //----------------------------------------
  // pin synchroniser
  //----------------------------------------
  // level moves only once stages two and three agree; a pin idling high shows one edge after reset
  wire [3:0] lvl_d = (s2_q ~^ s3_q) & s3_q | ~(s2_q ~^ s3_q) & lvl_q;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      lvl_q <= 4'h0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  //----------------------------------------
  // edge and match history
  //----------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_q <= 4'h0;
      cnt_eq_q <= 4'h0;
    end else begin
      prev_q <= {3'h0, i_osc_div_128_signal};
      cnt_eq_q <= match_now;
    end
  end

  //----------------------------------------
  // I/O control registers
  //----------------------------------------
  // reset leaves every channel comparing, channel A triggered from its pin
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      io_control_ab_q <= `RST_IO;
      io_control_cd_q <= `RST_IO;
    end else begin
      // unassigned bits store 0 whatever is written
      if (wr_ab) begin
        io_control_ab_q <= i_wdata & 8'h7f;
      end
      if (wr_cd) begin
        io_control_cd_q <= i_wdata & 8'h77;
      end
    end
  end

  //----------------------------------------
  // mode and buffer control
  //----------------------------------------
  // mode code 3 is undefined; it decodes as a compare-only mode
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      timer_mode_q <= `MODE_TIMER;
      buffer_a_enable_q <= 1'b0;
      buffer_b_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      timer_mode_q <= i_wdata[1:0];
      buffer_a_enable_q <= i_wdata[4];
      buffer_b_enable_q <= i_wdata[5];
    end
  end

  //----------------------------------------
  // status flags
  //----------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      flag_q <= 4'h0;
      wrap_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      wrap_q <= wrap_d;
    end
  end

  //----------------------------------------
  // clear arming
  //----------------------------------------
  // arm the clear only for bits read as 1; a status write disarms all unless a status read comes in the same cycle
  reg [4:0] seen_one_d;
  always @* begin
    seen_one_d = seen_one_q;
    if (rd_status) begin
      seen_one_d = cur_flags;
    end else if (wr_status) begin
      seen_one_d = 5'h00;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      seen_one_q <= 5'h00;
    end else begin
      seen_one_q <= seen_one_d;
    end
  end

  //----------------------------------------
  // status outputs
  //----------------------------------------
  // outputs take the next flag values so they never lag the internal flags
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_chan_event_flag <= 4'h0;
      o_counter_wrap_flag <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rdata_d : 8'h00;
      o_chan_event_flag <= flag_d;
      o_counter_wrap_flag <= wrap_d;
    end
  end

  //----------------------------------------
  // capture strobe
  //----------------------------------------
  // rises with the flag so the counter can be latched outside on that edge
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_capture_strobe <= 4'h0;
    end else begin
      o_capture_strobe <= cap_ev;
    end
  end

  //----------------------------------------
  // mode outputs
  //----------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_chan_capture_mode <= 4'h0;
      o_buffer_a_active <= 1'b0;
      o_buffer_b_active <= 1'b0;
    end else begin
      o_chan_capture_mode <= cap_mode;
      // mode bits of a buffer pair are assumed matched by software
      o_buffer_a_active <= buffer_a_enable_q;
      o_buffer_b_active <= buffer_b_enable_q;
    end
  end

endmodule // capture_compare_channel_ctrl

// File: verification/cc_properties.sv
// port assertions for the capture/compare channel control
`timescale 1ns/1ps
`include "capture_compare_regs.vh"
module cc_properties #(parameter CNT_W = 16) (
  input wire i_ref_clk, input wire i_rst, input wire [`ADDR_W-1:0] i_addr,
  input wire i_wr, input wire i_rd, input wire [7:0] o_rdata, input wire i_counter_wrap,
  input wire [CNT_W-1:0] i_timer_counter, input wire [CNT_W-1:0] i_general_reg_a,
  input wire [CNT_W-1:0] i_general_reg_b, input wire [CNT_W-1:0] i_general_reg_c,
  input wire [3:0] o_chan_event_flag, input wire o_counter_wrap_flag, input wire [3:0] o_chan_capture_mode
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wrap_sets_a: assert property (i_counter_wrap |-> ##[1:2] o_counter_wrap_flag) else $error("wrap flag missed");
  ab_read_a: assert property (i_rd && i_addr == `OFF_IO_AB |=> o_rdata[7]) else $error("ab spare bit low");
  cd_read_a: assert property (i_rd && i_addr == `OFF_IO_CD |=> o_rdata[7] && o_rdata[3]) else $error("cd spare low");
  flag_hold_a: assert property (!(i_wr && i_addr == `OFF_STATUS) |=> ({o_counter_wrap_flag, o_chan_event_flag}
    & $past({o_counter_wrap_flag, o_chan_event_flag})) == $past({o_counter_wrap_flag, o_chan_event_flag}))
    else $error("flag dropped without write");
  status_read_a: assert property (i_rd && i_addr == `OFF_STATUS |=> o_rdata == {$past(o_counter_wrap_flag), 3'h7,
    $past(o_chan_event_flag)}) else $error("status read wrong");
  match_a_a: assert property (i_timer_counter == i_general_reg_a && $past(i_timer_counter) != $past(i_general_reg_a)
    && !o_chan_capture_mode[0] |=> o_chan_event_flag[0]) else $error("match a missed");
  match_b_a: assert property (i_timer_counter == i_general_reg_b && $past(i_timer_counter) != $past(i_general_reg_b)
    && !o_chan_capture_mode[1] |=> o_chan_event_flag[1]) else $error("match b missed");
  match_c_a: assert property (i_timer_counter == i_general_reg_c && $past(i_timer_counter) != $past(i_general_reg_c)
    && !o_chan_capture_mode[2] |=> o_chan_event_flag[2]) else $error("match c missed");
endmodule // cc_properties

// File: verification/pin_model.sv
// pin and oscillator tap model for the capture inputs
`timescale 1ns/1ps
module pin_model (
  input wire i_ref_clk,
  input wire [3:0] i_toggle,
  output reg [3:0] o_pins,
  output reg o_osc
);
  reg [2:0] div_q = 3'h0;
  initial o_pins = 4'h0;
  initial o_osc = 1'b0;
  // short tap period, a true divide by 128 only stretches the run
  always @(posedge i_ref_clk) begin
    div_q <= div_q + 3'h1;
    o_osc <= div_q[2];
    o_pins <= o_pins ^ i_toggle;
  end
endmodule // pin_model

// File: verification/testbench.sv
// self-checking bench for the capture/compare channel control
`timescale 1ns/1ps
`include "capture_compare_regs.vh"
module testbench;
  reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  reg [9:0] addr = 10'h000;
  reg [7:0] wdata = 8'h00, got;
  reg [15:0] cnt = 16'h0000, ga = 16'h0100, gb = 16'h0100, gc = 16'h0100, gd = 16'h0100;
  reg [3:0] tog = 4'h0;
  wire [7:0] rdata;
  wire [3:0] flag, cmode, pins, stb;
  reg [3:0] stb_seen = 4'h0;
  wire wflag, osc, bfa, bfb;
  integer fails = 0, checks_done = 0, n;
  always #2 clk = ~clk;
  always @(posedge clk) cnt <= {8'h00, cnt[7:0] + 8'h01};
  always @(posedge clk) stb_seen <= stb_seen | stb;
  pin_model u_pins (.i_ref_clk(clk), .i_toggle(tog), .o_pins(pins), .o_osc(osc));
  capture_compare_channel_ctrl u_dut (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_timer_counter(cnt), .i_counter_wrap(cnt == 16'h00ff), .i_general_reg_a(ga),
    .i_general_reg_b(gb), .i_general_reg_c(gc), .i_general_reg_d(gd), .i_chan_a_pin(pins[0]), .i_chan_b_pin(pins[1]),
    .i_chan_c_pin(pins[2]), .i_chan_d_pin(pins[3]), .i_osc_div_128_signal(osc), .o_chan_event_flag(flag),
    .o_counter_wrap_flag(wflag), .o_capture_strobe(stb), .o_chan_capture_mode(cmode), .o_buffer_a_active(bfa),
    .o_buffer_b_active(bfb));
  task chk(input [7:0] g, input [7:0] e); begin
    checks_done = checks_done + 1;
    if (g !== e) begin fails = fails + 1; $display("FAIL %0t got %h exp %h", $time, g, e); end
  end endtask
  task wr8(input [9:0] a, input [7:0] d); begin
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1; @(posedge clk); wr <= 1'b0; @(posedge clk); #1;
  end endtask
  task rd8(input [9:0] a); begin
    @(posedge clk); addr <= a; rd <= 1'b1; @(posedge clk); rd <= 1'b0; #1 got = rdata;
  end endtask
  task tg(input [3:0] m); begin @(posedge clk); tog <= m; @(posedge clk); tog <= 4'h0; end endtask
  task clr; begin rd8(`OFF_STATUS); wr8(`OFF_STATUS, 8'h00); end endtask
  task wait_set(input [4:0] m); begin
    n = 0;
    while (({wflag, flag} & m) !== m && n < 600) begin @(posedge clk); n = n + 1; end
    if (n == 600) begin fails = fails + 1; $display("FAIL %0t flag wait ran out", $time); final_report; end
  end endtask
  task t_reset; begin
    rd8(`OFF_IO_AB); chk(got, 8'h88);
    rd8(`OFF_IO_CD); chk(got, 8'h88);
    rd8(`OFF_STATUS); chk(got, 8'h70);
    $display("reset test done");
  end endtask
  task t_regs; begin
    wr8(`OFF_IO_AB, 8'h7f); wr8(`OFF_IO_CD, 8'h77); rd8(`OFF_IO_AB); chk(got, 8'hff);
    rd8(`OFF_IO_CD); chk(got, 8'hff); chk({4'h0, cmode}, 8'h0f);
    wr8(`OFF_IO_AB, 8'h00); wr8(`OFF_IO_CD, 8'h00); rd8(`OFF_IO_AB); chk(got, 8'h80);
    rd8(`OFF_IO_CD); chk(got, 8'h88); chk({4'h0, cmode}, 8'h00);
    $display("register test done");
  end endtask
  task t_match; begin
    ga <= 16'h0020; gb <= 16'h0040; gc <= 16'h0060; gd <= 16'h0080;
    wait_set(5'h1f);
    wr8(`OFF_STATUS, 8'h00); chk({3'h0, wflag, flag}, 8'h1f);
    clr; chk({3'h0, wflag, flag}, 8'h00);
    ga <= 16'h0100; gb <= 16'h0100; gc <= 16'h0100; gd <= 16'h0100;
    $display("match test done");
  end endtask
  task t_capture; begin
    wr8(`OFF_IO_AB, 8'h5c); wr8(`OFF_IO_CD, 8'h06); clr;
    tg(4'h1); wait_set(5'h01);
    tg(4'h2); repeat (8) @(posedge clk); chk({7'h0, flag[1]}, 8'h00);
    tg(4'h2); wait_set(5'h02);
    tg(4'h4); wait_set(5'h04); clr; tg(4'h4); wait_set(5'h04);
    repeat (2) @(posedge clk); #1 chk({4'h0, stb_seen}, 8'h07);
    $display("capture test done");
  end endtask
  task t_osc; begin
    wr8(`OFF_IO_AB, 8'h04); clr; wait_set(5'h01);
    wr8(`OFF_IO_AB, 8'h0c); clr; repeat (40) @(posedge clk); chk({7'h0, flag[0]}, 8'h00);
    wr8(`OFF_IO_AB, 8'h00); clr; repeat (40) @(posedge clk); chk({7'h0, flag[0]}, 8'h00);
    $display("trigger source test done");
  end endtask
  task t_pwm; begin
    wr8(`OFF_IO_AB, 8'h44); wr8(`OFF_IO_CD, 8'h44); wr8(`OFF_CTRL, 8'h31);
    chk({4'h0, cmode}, 8'h00); chk({6'h0, bfa, bfb}, 8'h03);
    wr8(`OFF_CTRL, 8'h00); chk({4'h0, cmode}, 8'h0f);
    $display("mode test done");
  end endtask
  task final_report; begin
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  end endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset; t_regs; t_match; t_capture; t_osc; t_pwm;
    final_report;
  end
endmodule // testbench
bind capture_compare_channel_ctrl cc_properties #(.CNT_W(CNT_W)) u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_counter_wrap(i_counter_wrap),
  .i_timer_counter(i_timer_counter), .i_general_reg_a(i_general_reg_a), .i_general_reg_b(i_general_reg_b),
  .i_general_reg_c(i_general_reg_c), .o_chan_event_flag(o_chan_event_flag),
  .o_counter_wrap_flag(o_counter_wrap_flag), .o_chan_capture_mode(o_chan_capture_mode));
